/* core/irq_ctrl_pkg.sv */
// package: register map, reset values and types of the maskable irq control
//
// Behaviour
// RULE_01 - flag sets on source or software; clears on ack, software, reset
// RULE_02 - the request flag register takes single bit and whole byte writes
// RULE_03 - reset clears every request flag, register reads 00H
// RULE_04 - one mask bit per source, 0 permits, 1 blocks, bit or byte writes
// RULE_05 - reset sets every mask bit, register reads FFH
// RULE_06 - driving an irq pin as port output sets its flag; mask it first
// RULE_07 - two bit edge select per pin: 00 fall, 01 rise, 11 both, 10 banned
// RULE_08 - edge mode is byte written only, resets to 00H, spare bits zero
// RULE_09 - software masks, writes edge mode, clears flag, then unmasks
// RULE_10 - status word holds enable; byte, bit and on/off instruction access
// RULE_11 - reset loads the status word with 02H
// RULE_12 - eligible when flag 1 and mask 0; vectored only while enable is 1
// RULE_13 - servicing starts 9 to 19 cpu clocks after the request
// RULE_14 - worst latency comes with a request just before a bit test branch
// RULE_15 - simultaneous eligible requests taken highest fixed priority first
// RULE_16 - priority order: low voltage, pin a, pin b, timer match
// RULE_17 - a blocked request stays pending and is taken once conditions allow
// RULE_18 - ack pushes status word, then pc, clears enable, loads vector
// RULE_19 - a handler ends with the return from irq instruction
// RULE_20 - flag set before second to last clock: taken after that instruction
// RULE_21 - flag set in the last clock is taken after the next instruction
// RULE_22 - no ack while software accesses the request flag or mask register
// RULE_23 - after such an access, acceptance waits until next instruction ends
// RULE_24 - any unmasked source may nest once the handler sets enable again
// RULE_25 - pins synchronised before edge detection, one flag set per edge
package irq_ctrl_pkg;

   // register addresses on the cpu register port
   localparam logic [15:0] REQ_FLAG_ADDR   = 16'hFFE0;
   localparam logic [15:0] MASK_FLAG_ADDR  = 16'hFFE4;
   localparam logic [15:0] EDGE_MODE_ADDR  = 16'hFFEC;

   // values after reset
   localparam logic [7:0]  REQ_FLAG_RESET  = 8'h00;
   localparam logic [7:0]  MASK_FLAG_RESET = 8'hFF;
   localparam logic [7:0]  EDGE_MODE_RESET = 8'h00;
   localparam logic [7:0]  PSW_RESET       = 8'h02;

   // field layout
   localparam int          NUM_SRC         = 4;
   localparam int          SRC_LSB         = 1;
   localparam logic [7:0]  MASK_FIXED_ONES = 8'hE1;
   localparam logic [7:0]  EDGE_MODE_KEEP  = 8'h3C;
   localparam int          PIN_A_EDGE_LSB  = 2;
   localparam int          PIN_B_EDGE_LSB  = 4;
   localparam int          IE_BIT          = 7;
   localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

   // source indices, lowest index is highest priority
   localparam int          SRC_LOW_VOLT    = 0;
   localparam int          SRC_PIN_A       = 1;
   localparam int          SRC_PIN_B       = 2;
   localparam int          SRC_TIMER       = 3;

   // vector table entry per source index
   localparam logic [NUM_SRC-1:0][15:0] VECTOR_TABLE =
      {16'h000C, 16'h000A, 16'h0008, 16'h0006};

   // edge select codes
   localparam logic [1:0]  EDGE_FALL       = 2'h0;
   localparam logic [1:0]  EDGE_RISE       = 2'h1;
   localparam logic [1:0]  EDGE_BANNED     = 2'h2;
   localparam logic [1:0]  EDGE_BOTH       = 2'h3;

   // latency window, cpu clocks from request to servicing
   localparam int          ACK_MIN_CLOCKS  = 9;
   localparam int          ACK_MAX_CLOCKS  = 19;

   typedef logic [1:0] edge_sel_t;

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_PSW,
      SEQ_PC_HI,
      SEQ_PC_LO,
      SEQ_VECTOR
   } ack_seq_t;

endpackage

/* core/irq_pin_if.sv */
// interface between the controller and its external pin edge detector
`timescale 1ns/10ps
interface irq_pin_if;
   import irq_ctrl_pkg::*;

   logic      [1:0] pinLevel;
   edge_sel_t [1:0] edgeSel;
   logic      [1:0] edgePulse;

   modport ctrl (
      output pinLevel,
      output edgeSel,
      input  edgePulse
   );

   modport detect (
      input  pinLevel,
      input  edgeSel,
      output edgePulse
   );

endinterface

/* core/irq_edge_detect.sv */
// synchroniser and selectable edge detector for the two external irq pins
`timescale 1ns/10ps
module irq_edge_detect
   import irq_ctrl_pkg::*;
(
   input wire logic  sys_clk,
   input wire logic  rstn,
   irq_pin_if.detect pins
);

   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] prev;
      logic [1:0] pulse;
   } edge_state_t;

   edge_state_t st;
   edge_state_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // sync1 feeds only sync2; edges are taken between sync2 and prev
   always_comb begin
      next_st       = st;
      next_st.sync1 = pins.pinLevel; // RULE_25
      next_st.sync2 = st.sync1; // RULE_25
      next_st.prev  = st.sync2;
      for (int i = 0; i < 2; i++) begin
         unique case (pins.edgeSel[i]) // RULE_07
            EDGE_FALL:   next_st.pulse[i] = st.prev[i] & ~st.sync2[i];
            EDGE_RISE:   next_st.pulse[i] = ~st.prev[i] & st.sync2[i];
            EDGE_BOTH:   next_st.pulse[i] = st.prev[i] ^ st.sync2[i];
            EDGE_BANNED: next_st.pulse[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pins.edgePulse = st.pulse;

endmodule

/* core/maskable_interrupt_control.sv */
// maskable interrupt control: flags, masks, edge modes, status word, ack
`timescale 1ns/10ps
module maskable_interrupt_control
   import irq_ctrl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,

   // request sources
   input  wire logic        lowVoltRequest,
   input  wire logic        timerMatchRequest,
   input  wire logic        altIrqPortPinA,
   input  wire logic        altIrqPortPinB,

   // register port of the cpu core
   input  wire logic [15:0] sfrAddr,
   input  wire logic        sfrRead,
   input  wire logic        sfrWrite,
   input  wire logic        sfrBitWrite,
   input  wire logic [2:0]  sfrBitIdx,
   input  wire logic        sfrBitVal,
   input  wire logic [7:0]  sfrWrData,
   output logic      [7:0]  sfrRdData,

   // status word access from the cpu core
   input  wire logic        pswWrite,
   input  wire logic        pswBitWrite,
   input  wire logic [2:0]  pswBitIdx,
   input  wire logic        pswBitVal,
   input  wire logic [7:0]  pswWrData,
   input  wire logic        irqOnInstruction,
   input  wire logic        irqOffInstruction,
   input  wire logic        returnFromIrqInstruction,
   input  wire logic [7:0]  retiPsw,
   output logic      [7:0]  programStatusWord,

   // instruction sequencer
   input  wire logic        instrEnd,
   input  wire logic [15:0] curPc,
   output logic             cpuHold,
   output logic             stackWrite,
   output logic      [7:0]  stackData,
   output logic             vectorLoad,
   output logic      [15:0] vectorAddr,
   output logic             wakeRequest
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [NUM_SRC-1:0] reqFlag;
      logic [NUM_SRC-1:0] mask;
      logic [7:0]         edgeMode;
      logic [7:0]         program_status_word;
      ack_seq_t           seq;
      logic [15:0]        savedPc;
      logic               accessSeen;
      logic [7:0]         rdData;
      logic               stackWrite;
      logic [7:0]         stackData;
      logic               vectorLoad;
      logic [15:0]        vectorAddr;
   } ctrl_state_t;

   localparam ctrl_state_t CTRL_RESET = '{
      reqFlag:    REQ_FLAG_RESET[SRC_LSB +: NUM_SRC],
      mask:       MASK_FLAG_RESET[SRC_LSB +: NUM_SRC],
      edgeMode:   EDGE_MODE_RESET,
      program_status_word:        PSW_RESET,
      seq:        SEQ_IDLE,
      savedPc:    16'h0000,
      accessSeen: 1'b0,
      rdData:     8'h00,
      stackWrite: 1'b0,
      stackData:  8'h00,
      vectorLoad: 1'b0,
      vectorAddr: 16'h0000
   };

   ctrl_state_t st;
   ctrl_state_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // external pin edge detection

   irq_pin_if pinBus ();

   assign pinBus.pinLevel   = {altIrqPortPinB, altIrqPortPinA}; // RULE_06
   assign pinBus.edgeSel[0] = st.edgeMode[PIN_A_EDGE_LSB +: 2];
   assign pinBus.edgeSel[1] = st.edgeMode[PIN_B_EDGE_LSB +: 2];

   irq_edge_detect edgeDetect (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pins    (pinBus.detect)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode

   logic               selFlag;
   logic               selMask;
   logic               selEdge;
   logic               anyAccess;
   logic               flagMaskAccess;
   logic [NUM_SRC-1:0] hwSet;
   logic [7:0]         flagImage;
   logic [7:0]         maskImage;
   logic [7:0]         edgeImage;

   assign selFlag   = (sfrAddr == REQ_FLAG_ADDR);
   assign selMask   = (sfrAddr == MASK_FLAG_ADDR);
   assign selEdge   = (sfrAddr == EDGE_MODE_ADDR);
   assign anyAccess = sfrRead | sfrWrite | sfrBitWrite;

   // a read or write of the flag or mask register in this clock
   assign flagMaskAccess = anyAccess & (selFlag | selMask); // RULE_22

   always_comb begin
      hwSet               = '0;
      hwSet[SRC_LOW_VOLT] = lowVoltRequest; // RULE_01
      hwSet[SRC_PIN_A]    = pinBus.edgePulse[0]; // RULE_06
      hwSet[SRC_PIN_B]    = pinBus.edgePulse[1]; // RULE_06
      hwSet[SRC_TIMER]    = timerMatchRequest; // RULE_01
   end

   // byte images as software sees them
   always_comb begin
      flagImage = 8'h00;
      flagImage[SRC_LSB +: NUM_SRC] = st.reqFlag;
      maskImage = MASK_FIXED_ONES;
      maskImage[SRC_LSB +: NUM_SRC] = st.mask;
      edgeImage = st.edgeMode & EDGE_MODE_KEEP;
   end

   ////////////////////////////////////////////////////////////////////////////
   // eligibility and fixed priority

   logic [NUM_SRC-1:0] eligible;
   logic [1:0]         pick;
   logic               found;
   logic               blockAck;
   logic               acceptIrq;

   assign eligible = st.reqFlag & ~st.mask; // RULE_12

   always_comb begin
      pick  = 2'h0;
      found = 1'b0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            pick  = 2'(i); // RULE_15 RULE_16
            found = 1'b1;
         end
      end
   end

   // the instruction that touched flag or mask may not end in an ack
   assign blockAck = flagMaskAccess | st.accessSeen; // RULE_22 RULE_23

   // flags are registered, so one set in the last clock of an instruction
   // is seen only at the end of the following one
   assign acceptIrq = (st.seq == SEQ_IDLE) & instrEnd // RULE_20 RULE_21
                    & st.program_status_word[IE_BIT] & found & ~blockAck; // RULE_12 RULE_17

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [NUM_SRC-1:0] swSel;
      logic [NUM_SRC-1:0] swVal;
      logic [NUM_SRC-1:0] ackClr;
      logic [7:0]         edgeByte;

      swSel    = '0;
      swVal    = '0;
      ackClr   = '0;
      edgeByte = 8'h00;
      next_st  = st;

      next_st.stackWrite = 1'b0;
      next_st.vectorLoad = 1'b0;

      // register reads, answer one clock later
      if (sfrRead) begin
         if (selFlag) begin
            next_st.rdData = flagImage;
         end else if (selMask) begin
            next_st.rdData = maskImage;
         end else if (selEdge) begin
            next_st.rdData = edgeImage;
         end else begin
            next_st.rdData = READ_UNMAPPED;
         end
      end

      // software write pattern for flag and mask registers
      if (sfrWrite) begin
         swSel = '1; // RULE_02 RULE_04
         swVal = sfrWrData[SRC_LSB +: NUM_SRC];
      end else if (sfrBitWrite) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (sfrBitIdx == 3'(i + SRC_LSB)) begin
               swSel[i] = 1'b1; // RULE_02 RULE_04
            end
         end
         swVal = {NUM_SRC{sfrBitVal}};
      end

      // edge mode takes byte writes only, spare bits held at zero
      if (sfrWrite && selEdge) begin
         edgeByte         = sfrWrData & EDGE_MODE_KEEP;
         next_st.edgeMode = edgeByte; // RULE_08
      end

      // mask register
      if (selMask) begin
         next_st.mask = (st.mask & ~swSel) | (swSel & swVal); // RULE_04
      end

      // status word: return, byte, bit, on and off instructions
      if (returnFromIrqInstruction) begin
         next_st.program_status_word = retiPsw; // RULE_19
      end
      if (pswWrite) begin
         next_st.program_status_word = pswWrData; // RULE_10
      end
      if (pswBitWrite) begin
         next_st.program_status_word[pswBitIdx] = pswBitVal; // RULE_10
      end
      if (irqOnInstruction) begin
         next_st.program_status_word[IE_BIT] = 1'b1; // RULE_10 RULE_24
      end
      if (irqOffInstruction) begin
         next_st.program_status_word[IE_BIT] = 1'b0; // RULE_10
      end

      // access seen during the running instruction
      if (instrEnd) begin
         next_st.accessSeen = 1'b0;
      end else begin
         next_st.accessSeen = st.accessSeen | flagMaskAccess; // RULE_23
      end

      // acknowledge sequence
      unique case (st.seq)
         SEQ_IDLE: begin
            if (acceptIrq) begin
               ackClr[pick]          = 1'b1; // RULE_01
               next_st.seq           = SEQ_PSW;
               next_st.stackWrite    = 1'b1; // RULE_18
               next_st.stackData     = st.program_status_word; // RULE_18
               next_st.program_status_word[IE_BIT]   = 1'b0; // RULE_18
               next_st.savedPc       = curPc;
               next_st.vectorAddr    = VECTOR_TABLE[pick]; // RULE_18
            end
         end
         SEQ_PSW: begin
            next_st.seq        = SEQ_PC_HI;
            next_st.stackWrite = 1'b1; // RULE_18
            next_st.stackData  = st.savedPc[15:8];
         end
         SEQ_PC_HI: begin
            next_st.seq        = SEQ_PC_LO;
            next_st.stackWrite = 1'b1; // RULE_18
            next_st.stackData  = st.savedPc[7:0];
         end
         SEQ_PC_LO: begin
            next_st.seq        = SEQ_VECTOR;
            next_st.vectorLoad = 1'b1; // RULE_18
         end
         SEQ_VECTOR: begin
            next_st.seq = SEQ_IDLE;
         end
         default: begin
            next_st.seq = SEQ_IDLE;
         end
      endcase

      // request flags: a source set wins over any clear in the same clock
      if (selFlag) begin
         next_st.reqFlag = (st.reqFlag & ~ackClr & ~(swSel & ~swVal))
                         | (swSel & swVal) | hwSet; // RULE_01 RULE_02
      end else begin
         next_st.reqFlag = (st.reqFlag & ~ackClr) | hwSet; // RULE_01 RULE_17
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st <= CTRL_RESET; // RULE_03 RULE_05 RULE_08 RULE_11
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign sfrRdData         = st.rdData;
   assign programStatusWord = st.program_status_word;
   assign cpuHold           = (st.seq != SEQ_IDLE); // RULE_13 RULE_14
   assign stackWrite        = st.stackWrite;
   assign stackData         = st.stackData;
   assign vectorLoad        = st.vectorLoad;
   assign vectorAddr        = st.vectorAddr;
   assign wakeRequest       = |eligible;

endmodule

/* test/irq_ctrl_checker.sv */
// checker: port assertions of the maskable irq control
`timescale 1ns/10ps
module irq_ctrl_checker
   import irq_ctrl_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic [15:0] sfrAddr,
   input wire logic        sfrRead,
   input wire logic        sfrWrite,
   input wire logic        sfrBitWrite,
   input wire logic [7:0]  sfrRdData,
   input wire logic        pswWrite,
   input wire logic        pswBitWrite,
   input wire logic        irqOnInstruction,
   input wire logic        returnFromIrqInstruction,
   input wire logic [7:0]  retiPsw,
   input wire logic [7:0]  programStatusWord,
   input wire logic        instrEnd,
   input wire logic [15:0] curPc,
   input wire logic        cpuHold,
   input wire logic        stackWrite,
   input wire logic [7:0]  stackData,
   input wire logic        vectorLoad,
   input wire logic [15:0] vectorAddr,
   input wire logic        wakeRequest
);
   logic       ieBit;
   logic [7:0] pcHi;
   logic [7:0] pcLo;
   logic       regAcc;
   assign ieBit = programStatusWord[IE_BIT];
   assign pcHi = curPc[15:8];
   assign pcLo = curPc[7:0];
   assign regAcc = (sfrRead | sfrWrite | sfrBitWrite) &&
      (sfrAddr == REQ_FLAG_ADDR || sfrAddr == MASK_FLAG_ADDR);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////
   sequence sq_push;
      stackWrite[*3] ##1 (vectorLoad && !stackWrite) ##1 !cpuHold;
   endsequence
   sequence sq_pc;
      ##1 stackData == $past(pcHi, 2) ##1 stackData == $past(pcLo, 3);
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_ACK_CAUSE: assert property (
      $rose(cpuHold) |-> $past(instrEnd) && $past(ieBit) &&
      $past(wakeRequest)) else $error("ack without eligible request");
   AST_ACK_STEPS: assert property (
      $rose(cpuHold) |-> sq_push) else $error("ack steps wrong");
   AST_PSW_SAVE: assert property (
      $rose(cpuHold) |-> stackData == $past(programStatusWord) && !ieBit)
      else $error("status word push wrong");
   AST_PC_SAVE: assert property (
      $rose(cpuHold) |-> sq_pc) else $error("pc push wrong");
   AST_VECTOR: assert property (
      vectorLoad |-> vectorAddr inside {16'h0006, 16'h0008, 16'h000A,
      16'h000C}) else $error("vector address wrong");
   AST_IE_GATE: assert property (
      instrEnd && !ieBit |=> !$rose(cpuHold)) else $error("ack with ie 0");
   AST_ACCESS_HOLD: assert property (
      instrEnd && regAcc |=> !$rose(cpuHold))
      else $error("ack during register access");
   AST_FLAG_RD: assert property (
      sfrRead && sfrAddr == REQ_FLAG_ADDR |=> (sfrRdData & 8'hE1) == 8'h00)
      else $error("flag spare bits wrong");
   AST_MASK_RD: assert property (
      sfrRead && sfrAddr == MASK_FLAG_ADDR |=>
      (sfrRdData & 8'hE1) == 8'hE1) else $error("mask spare bits wrong");
   AST_EDGE_RD: assert property (
      sfrRead && sfrAddr == EDGE_MODE_ADDR |=>
      (sfrRdData & 8'hC3) == 8'h00) else $error("edge spare bits wrong");
   AST_RETURN_FROM_IRQ_INSTRUCTION: assert property (
      returnFromIrqInstruction |=> programStatusWord == $past(retiPsw))
      else $error("return did not restore status word");
   AST_IRQ_ON: assert property (
      irqOnInstruction && !returnFromIrqInstruction && !pswWrite &&
      !pswBitWrite |=> ieBit) else $error("enable instruction failed");
endmodule
bind maskable_interrupt_control irq_ctrl_checker i_chk (.sys_clk, .rstn,
   .sfrAddr, .sfrRead, .sfrWrite, .sfrBitWrite, .sfrRdData, .pswWrite,
   .pswBitWrite, .irqOnInstruction, .returnFromIrqInstruction, .retiPsw,
   .programStatusWord, .instrEnd, .curPc, .cpuHold, .stackWrite,
   .stackData, .vectorLoad, .vectorAddr, .wakeRequest);

/* test/cpu_seq_model.sv */
// model of the cpu instruction sequencer facing the irq control
`timescale 1ns/10ps
module cpu_seq_model #(
   parameter int INSTR_LEN = 4
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        cpuHold,
   input  wire logic        vectorLoad,
   input  wire logic [15:0] vectorAddr,
   output logic             instrEnd,
   output logic      [15:0] curPc
);
   int cnt;
   assign instrEnd = (cnt == INSTR_LEN - 1) && !cpuHold;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         curPc <= 16'h0100;
      end else if (vectorLoad) begin
         cnt <= 0;
         curPc <= vectorAddr;
      end else if (instrEnd) begin
         cnt <= 0;
         curPc <= curPc + 16'h0003;
      end else if (!cpuHold) begin
         cnt <= cnt + 1;
      end
   end
endmodule

/* test/testbench.sv */
// self-checking bench of the maskable irq control
`timescale 1ns/10ps
module testbench;
   import irq_ctrl_pkg::*;
   typedef struct {
      logic [15:0] addr;
      logic [7:0]  wdat;
      logic [7:0]  exp;
   } row_t;
   logic        sys_clk = 1'b0, rstn = 1'b0;
   logic        lowVoltReq = 1'b0, timerReq = 1'b0;
   logic        pinA = 1'b0, pinB = 1'b0;
   logic [15:0] sfrAddr = 16'h0000;
   logic        sfrRead = 1'b0, sfrWrite = 1'b0, sfrBitWrite = 1'b0;
   logic [2:0]  sfrBitIdx = 3'h0, pswBitIdx = 3'h0;
   logic        sfrBitVal = 1'b0, pswBitVal = 1'b0;
   logic [7:0]  sfrWrData = 8'h00, pswWrData = 8'h00, retiPsw = 8'h00;
   logic        pswWrite = 1'b0, pswBitWrite = 1'b0;
   logic        irqOn = 1'b0, irqOff = 1'b0, return_from_irq_instruction = 1'b0;
   logic [7:0]  sfrRdData, programStatusWord, stackData, psh;
   logic [15:0] curPc, vectorAddr;
   logic        instrEnd, cpuHold, stackWrite, vectorLoad, wakeRequest;
   logic [1:0]  r;
   int          num_errors = 0, total_checks = 0, vecCount = 0, n0;
   logic [1:0]  codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   row_t        rows [7] = '{'{16'hFFE0, 8'hFF, 8'h1E},
      '{16'hFFE0, 8'h00, 8'h00}, '{16'hFFE4, 8'h00, 8'hE1},
      '{16'hFFE4, 8'hFF, 8'hFF}, '{16'hFFEC, 8'h3C, 8'h3C},
      '{16'hFFEC, 8'h00, 8'h00}, '{16'hFFF0, 8'h55, 8'h00}};
   always #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (vectorLoad) vecCount++;
   ////////////////////////////////////////////////////////////////////////
   maskable_interrupt_control i_dut (.sys_clk, .rstn,
      .lowVoltRequest(lowVoltReq), .timerMatchRequest(timerReq),
      .altIrqPortPinA(pinA), .altIrqPortPinB(pinB), .sfrAddr, .sfrRead,
      .sfrWrite, .sfrBitWrite, .sfrBitIdx, .sfrBitVal, .sfrWrData,
      .sfrRdData, .pswWrite, .pswBitWrite, .pswBitIdx, .pswBitVal,
      .pswWrData, .irqOnInstruction(irqOn), .irqOffInstruction(irqOff),
      .returnFromIrqInstruction(return_from_irq_instruction), .retiPsw, .programStatusWord,
      .instrEnd, .curPc, .cpuHold, .stackWrite, .stackData, .vectorLoad,
      .vectorAddr, .wakeRequest);
   cpu_seq_model #(.INSTR_LEN(4)) i_cpu (.sys_clk, .rstn, .cpuHold,
      .vectorLoad, .vectorAddr, .instrEnd, .curPc);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge sys_clk);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      sfrAddr = a;
      sfrWrData = d;
      pulse(sfrWrite);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      sfrAddr = a;
      pulse(sfrRead);
      check(sfrRdData, e);
   endtask
   task automatic waitVec(input logic [15:0] exp);
      bit seen = 1'b0;
      for (int n = 0; n < 60 && !vectorLoad; n++) begin
         @(negedge sys_clk);
         if (stackWrite && !seen) begin
            psh = stackData;
            seen = 1'b1;
         end
      end
      check(vectorAddr, exp);
      check(psh, 8'h82);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      rstn = 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdat);
         rd(rows[i].addr, rows[i].exp);
      end
      $display("register table done");
      wr(MASK_FLAG_ADDR, 8'hE1);
      wr(REQ_FLAG_ADDR, 8'h1E);
      pulse(irqOn);
      for (int i = 0; i < 4; i++) begin
         waitVec(16'h0006 + 16'(2 * i));
         if (i == 3) rd(REQ_FLAG_ADDR, 8'h00);
         retiPsw = psh;
         pulse(return_from_irq_instruction);
      end
      $display("priority test done");
      wr(MASK_FLAG_ADDR, 8'hF1);
      pulse(timerReq);
      n0 = vecCount;
      repeat (30) @(negedge sys_clk);
      check(16'(vecCount), 16'(n0));
      rd(REQ_FLAG_ADDR, 8'h10);
      wr(MASK_FLAG_ADDR, 8'hE1);
      waitVec(16'h000C);
      pulse(irqOff);
      $display("mask test done");
      pulse(lowVoltReq);
      rd(REQ_FLAG_ADDR, 8'h02);
      sfrAddr = REQ_FLAG_ADDR;
      sfrBitIdx = 3'h1;
      pulse(sfrBitWrite);
      rd(REQ_FLAG_ADDR, 8'h00);
      foreach (codes[k]) begin
         wr(MASK_FLAG_ADDR, 8'hFF);
         wr(EDGE_MODE_ADDR, {2'h0, codes[k], codes[k], 2'h0});
         repeat (4) @(negedge sys_clk);
         wr(REQ_FLAG_ADDR, 8'h00);
         wr(MASK_FLAG_ADDR, 8'hE1);
         pinA = 1'b1;
         pinB = 1'b1;
         repeat (5) @(negedge sys_clk);
         r = {2{codes[k] == 2'h1 || codes[k] == 2'h3}};
         rd(REQ_FLAG_ADDR, {4'h0, r, 2'h0});
         wr(REQ_FLAG_ADDR, 8'h00);
         pinA = 1'b0;
         pinB = 1'b0;
         repeat (5) @(negedge sys_clk);
         r = {2{codes[k] == 2'h0 || codes[k] == 2'h3}};
         rd(REQ_FLAG_ADDR, {4'h0, r, 2'h0});
      end
      $display("edge test done");
      pswWrData = 8'h85;
      pulse(pswWrite);
      check(programStatusWord, 8'h85);
      pswBitIdx = 3'h7;
      pulse(pswBitWrite);
      check(programStatusWord, 8'h05);
      pulse(irqOn);
      check(programStatusWord, 8'h85);
      pulse(irqOff);
      check(programStatusWord, 8'h05);
      $display("status word test done");
      rstn = 1'b0;
      repeat (3) @(negedge sys_clk);
      check(programStatusWord, 8'h02);
      rstn = 1'b1;
      rd(REQ_FLAG_ADDR, 8'h00);
      rd(MASK_FLAG_ADDR, 8'hFF);
      rd(EDGE_MODE_ADDR, 8'h00);
      $display("reset test done");
      conclude();
   end
endmodule
